// ===== rtl/sie_cfg.svh
// constants for the safety input channel evaluator
`ifndef SIE_CFG_SVH
`define SIE_CFG_SVH

// clock and time base
`define CLK_PERIOD_NS  10
`define MS_NS          1000000
`define CLK_PER_MS     (`MS_NS / `CLK_PERIOD_NS)
`define LATCH_STEP_MS  10
`define DELAY_STEP_MS  6
`define DELAY_MAX_STEP 5'h15
`define PT_SLOT_MS     4'h4
// test output register plus the two synchroniser flops
`define SYNC_LAT       3

// sizes
`define NUM_POINTS     8
`define NUM_PAIRS      4
`define NUM_SOURCES    4

// register byte addresses
`define ADDR_STATE     8'h00
`define ADDR_ERROR     8'h04
`define ADDR_LATCH     8'h08
`define ADDR_TEST      8'h0c
`define ADDR_PAIR0     8'h10
`define ADDR_POINT0    8'h20
`define ADDR_END       8'h40

// field positions
`define F_MODE_LSB     0
`define F_SRC_LSB      2
`define F_ON_LSB       5
`define F_OFF_LSB      10
`define F_OP_LSB       0
`define F_DISC_LSB     16
`define F_LAMP_LSB     4
`define F_CYC_LSB      8
`define F_DISC_ERR_LSB 8

// reset values and masks
`define LATCH_RESET    13'h0064
`define MUTE_CAPABLE   4'ha

`endif

// ===== rtl/sie_pkg.sv
// types shared by the safety input channel evaluator
package sie_pkg;

   typedef enum logic [1:0] {
      MODE_NOT_USED   = 2'h0,
      MODE_PULSE_TEST = 2'h1,
      MODE_SAFETY     = 2'h2,
      MODE_STANDARD   = 2'h3
   } point_mode_t;

   typedef enum logic [1:0] {
      OP_SINGLE        = 2'h0,
      OP_EQUIVALENT    = 2'h1,
      OP_COMPLEMENTARY = 2'h2,
      OP_RESERVED      = 2'h3
   } op_type_t;

   typedef struct packed {
      logic [4:0]  off_steps;
      logic [4:0]  on_steps;
      logic [2:0]  src;
      point_mode_t mode;
   } point_cfg_t;

   typedef struct packed {
      logic [15:0] disc_ms;
      op_type_t    op;
   } pair_cfg_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

endpackage

// ===== rtl/input_filter.sv
// per-channel on and off delay filter
`timescale 1ns/1ps
`include "sie_cfg.svh"

module input_filter
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // time base and settings
   input  wire logic       ms_tick,
   input  wire logic [4:0] on_steps,
   input  wire logic [4:0] off_steps,
   // channel
   input  wire logic       raw,
   output logic            filt
);

   logic [6:0] cnt_q;
   logic [7:0] target;
   logic       filt_q;

   // delay in ms picked by the direction of the pending change
   always_comb
   begin
      if (filt_q)
         target = 8'(off_steps * `DELAY_STEP_MS);
      else
         target = 8'(on_steps * `DELAY_STEP_MS);
   end

   // any bounce restarts the count, so the level must still hold at the end
   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_q <= 7'h00;
      else if (raw == filt_q)
         cnt_q <= 7'h00;
      else if (ms_tick && ({1'b0, cnt_q} < target))
         cnt_q <= cnt_q + 7'h01;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         filt_q <= 1'b0;
      else if ((raw != filt_q) && ({1'b0, cnt_q} >= target))
         filt_q <= raw;
   end

   assign filt = filt_q;

endmodule

// ===== rtl/safety_input_eval.sv
// safety input channel evaluator with apb register access
//
// Function
// - single points evaluated alone, never paired
// - pulse test runs per channel, ignoring pairing
// - equivalent pair errors if mismatched past time
// - complementary pair errors if not opposite past time
// - zero discrepancy time never raises fault
// - zero time still forces safe state on cycle
// - cycle needed when one drops, returns, other held
// - pair stays inactive until both reach safe
// - logical state may differ from terminals then
// - unused point always reads zero
// - pulse-tested point checked against own test source
// - safety mode point never pulse checked
// - standard point never takes part in pairing
// - wrong or missing source gives pulse failures
// - only test outputs one and three mute
// - on delay 0..126 ms, 6 ms steps
// - off delay per channel, same range
// - errors latched 0..81910 ms, 10 ms steps
// - discrepancy faults exposed in error register
`timescale 1ns/1ps
`include "sie_cfg.svh"

module safety_input_eval
#(
   parameter int MS_CYCLES = `CLK_PER_MS
)
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // register bus
   input  wire sie_pkg::apb_req_t apb_req,
   output sie_pkg::apb_rsp_t    apb_rsp,
   // field terminals
   input  wire logic [7:0]      in_pin,
   output logic [3:0]           test_out,
   // evaluated points
   output logic [7:0]           eval_out
);
   import sie_pkg::*;

   // register file
   point_cfg_t  point_q [`NUM_POINTS];
   pair_cfg_t   pair_q  [`NUM_PAIRS];
   logic [12:0] latch_q;
   logic [3:0]  mute_q;
   logic [3:0]  lamp_q;
   logic [31:0] prdata_q;

   // time base
   logic [16:0] ms_cnt_q;
   logic [3:0]  ten_cnt_q;
   logic        ms_tick;
   logic        ten_tick;

   // inputs
   logic [7:0]  sync1_q;
   logic [7:0]  sync2_q;
   logic [7:0]  hold_q;
   logic [7:0]  filt;

   // pulse engine
   logic [1:0]  slot_q;
   logic [3:0]  slot_ms_q;
   logic [3:0]  pulsing;
   logic [7:0]  own_pulse;
   logic [7:0]  pt_fail;

   // evaluation
   logic [3:0]  paired;
   logic [3:0]  pair_ok;
   logic [3:0]  cyc_flag;
   logic [3:0]  disc_now;
   logic [11:0] err_now;
   logic [11:0] err_q;
   logic [7:0]  eval_d;
   logic [7:0]  eval_q;
   logic [3:0]  test_q;

   // bus access decode
   function automatic logic addr_mapped(input logic [7:0] a);
      addr_mapped = (a < `ADDR_END) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic is_point(input logic [7:0] a);
      is_point = (a >= `ADDR_POINT0) && (a < `ADDR_END);
   endfunction

   function automatic logic is_pair(input logic [7:0] a);
      is_pair = (a >= `ADDR_PAIR0) && (a < `ADDR_POINT0);
   endfunction

   // a point can join its pair only in a safety mode
   function automatic logic pair_capable(input point_cfg_t c);
      pair_capable = (c.mode == MODE_PULSE_TEST) || (c.mode == MODE_SAFETY);
   endfunction

   logic       wr_en;
   logic       setup;
   logic [2:0] pt_idx;
   logic [1:0] pr_idx;

   assign setup  = apb_req.psel && !apb_req.penable;
   assign wr_en  = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                   addr_mapped(apb_req.paddr);
   assign pt_idx = 3'((apb_req.paddr - `ADDR_POINT0) >> 2);
   assign pr_idx = 2'((apb_req.paddr - `ADDR_PAIR0) >> 2);

   // zero wait states, unmapped words answer with an error
   always_comb
   begin
      apb_rsp.pready  = 1'b1;
      apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
                        !addr_mapped(apb_req.paddr);
      apb_rsp.prdata  = prdata_q;
   end

   // configuration writes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < `NUM_POINTS; i++)
            point_q[i] <= '0;
         for (int p = 0; p < `NUM_PAIRS; p++)
            pair_q[p] <= '0;
      end
      else if (wr_en && is_point(apb_req.paddr))
      begin
         point_q[pt_idx].mode <= point_mode_t'(apb_req.pwdata[`F_MODE_LSB +: 2]);
         point_q[pt_idx].src  <= apb_req.pwdata[`F_SRC_LSB +: 3];
         point_q[pt_idx].on_steps <=
            (apb_req.pwdata[`F_ON_LSB +: 5] > `DELAY_MAX_STEP) ?
            `DELAY_MAX_STEP : apb_req.pwdata[`F_ON_LSB +: 5];
         point_q[pt_idx].off_steps <=
            (apb_req.pwdata[`F_OFF_LSB +: 5] > `DELAY_MAX_STEP) ?
            `DELAY_MAX_STEP : apb_req.pwdata[`F_OFF_LSB +: 5];
      end
      else if (wr_en && is_pair(apb_req.paddr))
      begin
         pair_q[pr_idx].op      <= op_type_t'(apb_req.pwdata[`F_OP_LSB +: 2]);
         pair_q[pr_idx].disc_ms <= apb_req.pwdata[`F_DISC_LSB +: 16];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         latch_q <= `LATCH_RESET;
         mute_q  <= 4'h0;
         lamp_q  <= 4'h0;
      end
      else if (wr_en && (apb_req.paddr == `ADDR_LATCH))
         latch_q <= apb_req.pwdata[12:0];
      else if (wr_en && (apb_req.paddr == `ADDR_TEST))
      begin
         mute_q <= apb_req.pwdata[3:0] & `MUTE_CAPABLE;
         lamp_q <= apb_req.pwdata[`F_LAMP_LSB +: 4];
      end
   end

   // read data captured in the setup phase
   always_ff @(posedge clk)
   begin
      if (rst)
         prdata_q <= 32'h0000_0000;
      else if (setup)
      begin
         prdata_q <= 32'h0000_0000;
         if (apb_req.paddr == `ADDR_STATE)
            prdata_q <= {20'h0_0000, cyc_flag, eval_q};
         else if (apb_req.paddr == `ADDR_ERROR)
            prdata_q <= {20'h0_0000, err_q};
         else if (apb_req.paddr == `ADDR_LATCH)
            prdata_q <= {19'h0_0000, latch_q};
         else if (apb_req.paddr == `ADDR_TEST)
            prdata_q <= {24'h00_0000, lamp_q, mute_q};
         else if (is_pair(apb_req.paddr) && addr_mapped(apb_req.paddr))
            prdata_q <= {pair_q[pr_idx].disc_ms, 14'h0000,
                         pair_q[pr_idx].op};
         else if (is_point(apb_req.paddr) && addr_mapped(apb_req.paddr))
            prdata_q <= {17'h0_0000, point_q[pt_idx].off_steps,
                         point_q[pt_idx].on_steps, point_q[pt_idx].src,
                         point_q[pt_idx].mode};
      end
   end

   // millisecond and ten millisecond ticks
   assign ms_tick  = (ms_cnt_q == 17'(MS_CYCLES - 1));
   assign ten_tick = ms_tick && (ten_cnt_q == 4'(`LATCH_STEP_MS - 1));

   always_ff @(posedge clk)
   begin
      if (rst || ms_tick)
         ms_cnt_q <= 17'h0_0000;
      else
         ms_cnt_q <= ms_cnt_q + 17'h0_0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst || ten_tick)
         ten_cnt_q <= 4'h0;
      else if (ms_tick)
         ten_cnt_q <= ten_cnt_q + 4'h1;
   end

   // terminals come from the field, two flops before use
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sync1_q <= 8'h00;
         sync2_q <= 8'h00;
      end
      else
      begin
         sync1_q <= in_pin;
         sync2_q <= sync1_q;
      end
   end

   // pulse engine: each unmuted source is pulled low for the first ms of its slot
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         slot_q    <= 2'h0;
         slot_ms_q <= 4'h0;
      end
      else if (ms_tick)
      begin
         if (slot_ms_q == `PT_SLOT_MS - 4'h1)
         begin
            slot_ms_q <= 4'h0;
            slot_q    <= slot_q + 2'h1;
         end
         else
            slot_ms_q <= slot_ms_q + 4'h1;
      end
   end

   generate
      for (genvar k = 0; k < `NUM_SOURCES; k++)
      begin : g_src
         // a muting output drives its lamp instead of pulsing
         assign pulsing[k] = (slot_q == 2'(k)) && (slot_ms_q == 4'h0) &&
                             !mute_q[k];
         always_ff @(posedge clk)
         begin
            if (rst)
               test_q[k] <= 1'b1;
            else if (mute_q[k])
               test_q[k] <= lamp_q[k];
            else
               test_q[k] <= !pulsing[k];
         end
      end
   endgenerate

   assign test_out = test_q;

   // per channel: pulse check and filtering
   generate
      for (genvar i = 0; i < `NUM_POINTS; i++)
      begin : g_pt
         logic [2:0] src;
         logic       pt_mode;
         logic       masked;
         logic [`SYNC_LAT-1:0] pdly_q;
         assign src     = point_q[i].src;
         assign pt_mode = (point_q[i].mode == MODE_PULSE_TEST);
         // source codes: 0 none, 1..4 test outputs 0..3
         assign own_pulse[i] = pt_mode && (src != 3'h0) &&
                               pulsing[2'(src - 3'h1)];
         // the pulse reaches sync2 late, so the mask trails it; without
         // this the filter would see a short false drop after each pulse
         always_ff @(posedge clk)
         begin
            if (rst)
               pdly_q <= '0;
            else
               pdly_q <= {pdly_q[`SYNC_LAT-2:0], own_pulse[i]};
         end
         assign masked = own_pulse[i] || (pdly_q != '0);
         // the level seen during our own pulse is the test, not the switch
         always_ff @(posedge clk)
         begin
            if (rst)
               hold_q[i] <= 1'b0;
            else if (!masked)
               hold_q[i] <= sync2_q[i];
         end
         // still high at the end of our pulse: short to supply, a cross
         // short or a wrong source; a missing source always fails
         assign pt_fail[i] = pt_mode &&
            ((src == 3'h0) || (src > 3'(`NUM_SOURCES)) ||
             (own_pulse[i] && ms_tick && sync2_q[i] && hold_q[i]));
         input_filter u_filt
         (
            .clk       (clk),
            .rst       (rst),
            .ms_tick   (ms_tick),
            .on_steps  (point_q[i].on_steps),
            .off_steps (point_q[i].off_steps),
            .raw       (masked ? hold_q[i] : sync2_q[i]),
            .filt      (filt[i])
         );
      end
   endgenerate

   // pair evaluation
   typedef enum logic [4:0] {
      CY_IDLE  = 5'h01,
      CY_BOTH  = 5'h02,
      CY_ADROP = 5'h04,
      CY_BDROP = 5'h08,
      CY_LOCK  = 5'h10
   } cycle_state_t;

   generate
      for (genvar p = 0; p < `NUM_PAIRS; p++)
      begin : g_pair
         cycle_state_t st_q;
         cycle_state_t st_d;
         logic [15:0]  dcnt_q;
         logic         na;
         logic         nb;
         logic         comp;
         assign comp = (pair_q[p].op == OP_COMPLEMENTARY);
         assign paired[p] = ((pair_q[p].op == OP_EQUIVALENT) || comp) &&
                            pair_capable(point_q[2*p]) &&
                            pair_capable(point_q[2*p+1]);
         // active level of the second channel flips when complementary
         assign na = filt[2*p];
         assign nb = comp ? !filt[2*p+1] : filt[2*p+1];

         // timer runs only while the relation is broken
         always_ff @(posedge clk)
         begin
            if (rst || !paired[p] || (na == nb))
               dcnt_q <= 16'h0000;
            else if (ms_tick && (dcnt_q != 16'hffff))
               dcnt_q <= dcnt_q + 16'h0001;
         end
         assign disc_now[p] = paired[p] && (na != nb) &&
                              (pair_q[p].disc_ms != 16'h0000) &&
                              (dcnt_q >= pair_q[p].disc_ms);

         always_comb
         begin
            st_d = st_q;
            case (st_q)
               CY_IDLE:
                  if (na && nb)
                     st_d = CY_BOTH;
               CY_BOTH:
                  if (!na && nb)
                     st_d = CY_ADROP;
                  else if (na && !nb)
                     st_d = CY_BDROP;
                  else if (!na && !nb)
                     st_d = CY_IDLE;
               CY_ADROP:
                  if (!nb)
                     st_d = CY_IDLE;
                  else if (na)
                     st_d = CY_LOCK;
               CY_BDROP:
                  if (!na)
                     st_d = CY_IDLE;
                  else if (nb)
                     st_d = CY_LOCK;
               CY_LOCK:
                  if (!na && !nb)
                     st_d = CY_IDLE;
               default:
                  st_d = CY_IDLE;
            endcase
         end

         always_ff @(posedge clk)
         begin
            if (rst || !paired[p])
               st_q <= CY_IDLE;
            else
               st_q <= st_d;
         end

         // safe state in lock, no fault of its own
         assign cyc_flag[p] = (st_q == CY_LOCK);
         assign pair_ok[p]  = (st_q == CY_BOTH) && !disc_now[p];
      end
   endgenerate

   // error latch: held for the latch time after the cause is gone
   assign err_now = {disc_now, pt_fail};

   generate
      for (genvar e = 0; e < `NUM_POINTS + `NUM_PAIRS; e++)
      begin : g_err
         logic [12:0] lcnt_q;
         always_ff @(posedge clk)
         begin
            if (rst || err_now[e])
               lcnt_q <= 13'h0000;
            else if (err_q[e] && ten_tick)
               lcnt_q <= lcnt_q + 13'h0001;
         end
         always_ff @(posedge clk)
         begin
            if (rst)
               err_q[e] <= 1'b0;
            else if (err_now[e])
               err_q[e] <= 1'b1;
            else if (lcnt_q >= latch_q)
               err_q[e] <= 1'b0;
         end
      end
   endgenerate

   // evaluated point value
   always_comb
   begin
      for (int i = 0; i < `NUM_POINTS; i++)
      begin
         if (point_q[i].mode == MODE_NOT_USED)
            eval_d[i] = 1'b0;
         else if (paired[i/2])
            eval_d[i] = pair_ok[i/2];
         else
            eval_d[i] = filt[i] && !err_q[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         eval_q <= 8'h00;
      else
         eval_q <= eval_d;
   end

   assign eval_out = eval_q;

endmodule

// ===== testbench/sie_checker_asserts.sv
// port-level property checker for the safety input channel evaluator
`timescale 1ns/1ps

module sie_checker
#(
   parameter int MS_CYCLES = 100000
)
(
   // clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // register bus
   input wire sie_pkg::apb_req_t apb_req,
   input wire sie_pkg::apb_rsp_t apb_rsp,
   // field side
   input wire logic [7:0]        in_pin,
   input wire logic [3:0]        test_out,
   input wire logic [7:0]        eval_out
);
   import sie_pkg::*;

   logic        acc_w;
   logic [31:0] low_q;
   logic [7:0]  unused_q;
   logic [3:0]  age_q;

   assign acc_w = apb_req.psel & apb_req.penable;

   // length of the running low pulse on the first source
   always_ff @(posedge clk)
      if (rst || test_out[0])
         low_q <= '0;
      else
         low_q <= low_q + 32'h1;

   // unused points snooped from writes
   always_ff @(posedge clk)
      if (rst)
         unused_q <= 8'hff;
      else if (acc_w && apb_req.pwrite && apb_req.paddr[7:5] == 3'h1
               && apb_req.paddr[1:0] == 2'h0)
         unused_q[apb_req.paddr[4:2]] <= apb_req.pwdata[1:0] == 2'h0;

   // eval lags a config write by a few cycles, so wait before judging
   always_ff @(posedge clk)
      if (rst || (acc_w && apb_req.pwrite))
         age_q <= 4'h0;
      else if (age_q != 4'h8)
         age_q <= age_q + 4'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_ready_high:
      assert property (apb_rsp.pready)
      else $error("pready low");
   chk_err_decode:
      assert property (acc_w |-> apb_rsp.pslverr ==
         (apb_req.paddr >= 8'h40 || apb_req.paddr[1:0] != 2'h0))
      else $error("pslverr wrong for address");
   chk_unmapped_zero:
      assert property (acc_w && !apb_req.pwrite && apb_req.paddr >= 8'h40
         |-> apb_rsp.prdata == 32'h0)
      else $error("unmapped read data not zero");
   chk_state_mirror:
      assert property (apb_req.psel && !apb_req.penable && !apb_req.pwrite
         && apb_req.paddr == 8'h00 |=> apb_rsp.prdata[7:0] == $past(eval_out))
      else $error("state read differs from eval");
   chk_mute_odd_only:
      assert property (acc_w && !apb_req.pwrite && apb_req.paddr == 8'h0c
         |-> apb_rsp.prdata[0] == 1'b0 && apb_rsp.prdata[2] == 1'b0)
      else $error("mute bit on even source");
   chk_pulse_apart:
      assert property (test_out[0] || test_out[2])
      else $error("two test sources low together");
   chk_pulse_width:
      assert property ($rose(test_out[0]) |-> low_q == MS_CYCLES)
      else $error("test pulse not one ms long");
   chk_unused_zero:
      assert property (age_q == 4'h8 |-> (eval_out & unused_q) == 8'h00)
      else $error("unused point reads one");
endmodule

bind safety_input_eval sie_checker #(.MS_CYCLES(MS_CYCLES)) u_chk
(
   .clk      (clk),
   .rst      (rst),
   .apb_req  (apb_req),
   .apb_rsp  (apb_rsp),
   .in_pin   (in_pin),
   .test_out (test_out),
   .eval_out (eval_out)
);

// ===== testbench/field_model.sv
// switches wired to supply or to a test source
`timescale 1ns/1ps

module field_model
(
   // test source levels
   input  wire logic [3:0]  test_out,
   // switch states, wiring per point (0 supply, n source n-1)
   input  wire logic [7:0]  sw_on,
   input  wire logic [23:0] feed,
   // terminal levels
   output logic [7:0]       in_pin
);
   logic [2:0] src;

   // a switch passes whatever feeds it; supply wiring acts as a short
   always_comb
   begin
      src = 3'h0;
      for (int i = 0; i < 8; i++)
      begin
         src = feed[3*i +: 3];
         in_pin[i] = sw_on[i] &
            (src == 3'h0 ? 1'b1 : test_out[2'(src - 3'h1)]);
      end
   end
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the safety input channel evaluator
`timescale 1ns/1ps

module tb_top;
   import sie_pkg::*;

   localparam int MSC = 20;

   logic        clk;
   logic        rst;
   apb_req_t    req;
   apb_rsp_t    rsp;
   logic [7:0]  in_pin;
   logic [3:0]  test_out;
   logic [7:0]  eval_out;
   logic [7:0]  sw;
   logic [23:0] feed;
   logic [31:0] rdata;
   logic        rerr;
   int          bad_count;
   int          total_checks;

   safety_input_eval #(.MS_CYCLES(MSC)) uut
   (
      .clk      (clk),
      .rst      (rst),
      .apb_req  (req),
      .apb_rsp  (rsp),
      .in_pin   (in_pin),
      .test_out (test_out),
      .eval_out (eval_out)
   );

   field_model fm
   (
      .test_out (test_out),
      .sw_on    (sw),
      .feed     (feed),
      .in_pin   (in_pin)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         $display("wrong value %s: expected %h, seen %h", what, e, g);
         bad_count++;
      end
   endtask

   // one apb transfer; waits on pready, bounded
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk);
         if (rsp.pready === 1'b1)
            break;
      end
      rdata = rsp.prdata;
      rerr = rsp.pslverr;
      req <= '0;
      if (n == 20)
      begin
         bad_count++;
         test_done;
      end
   endtask

   task rc(input logic [7:0] a, input logic [31:0] m, e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg_%h", a), e, rdata & m);
   endtask

   task ec(input logic [7:0] m, e);
      chk("eval_out", {24'h0, e}, {24'h0, eval_out & m});
   endtask

   task ms(input int n);
      repeat (n * MSC) @(posedge clk);
   endtask

   task pt(input int i, input logic [1:0] md, input logic [2:0] s,
           input logic [4:0] on, off);
      xfer(1'b1, 8'h20 + 8'(4 * i), {17'h0, off, on, s, md});
   endtask

   task pr(input int p, input logic [1:0] op, input logic [15:0] t);
      xfer(1'b1, 8'h10 + 8'(4 * p), {t, 14'h0, op});
   endtask

   initial
   begin
      rst = 1'b1;
      req = '0;
      sw = 8'h0;
      feed = 24'h0;
      bad_count = 0;
      total_checks = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rc(8'h08, 32'hffffffff, 32'h64);
      xfer(1'b0, 8'h44, 32'h0);
      chk("pslverr", 32'h1, {31'h0, rerr});
      chk("prdata", 32'h0, rdata);
      xfer(1'b1, 8'h0c, 32'hff);
      rc(8'h0c, 32'hff, 32'hfa);
      xfer(1'b1, 8'h0c, 32'h02);
      ms(20);
      chk("test_out", 32'h0, {31'h0, test_out[1]});
      xfer(1'b1, 8'h0c, 32'h0);
      sw <= 8'hff;
      ms(1);
      ec(8'hff, 8'h00);
      sw <= 8'h00;
      // plain safety point, 6 ms on and 12 ms off
      pt(0, MODE_SAFETY, 3'h0, 5'h1, 5'h2);
      ms(2);
      sw[0] <= 1'b1;
      repeat (110) @(posedge clk);
      ec(8'h01, 8'h00);
      repeat (50) @(posedge clk);
      ec(8'h01, 8'h01);
      sw[0] <= 1'b0;
      repeat (230) @(posedge clk);
      ec(8'h01, 8'h01);
      repeat (70) @(posedge clk);
      ec(8'h01, 8'h00);
      rc(8'h04, 32'h1, 32'h0);
      // pulse tested point; latch long enough to outlive a round
      xfer(1'b1, 8'h08, 32'h5);
      sw[1] <= 1'b1;
      feed[5:3] <= 3'h1;
      pt(1, MODE_PULSE_TEST, 3'h1, 5'h0, 5'h0);
      ms(20);
      rc(8'h04, 32'h2, 32'h0);
      ec(8'h02, 8'h02);
      feed[5:3] <= 3'h0;
      ms(20);
      rc(8'h04, 32'h2, 32'h2);
      ec(8'h02, 8'h00);
      feed[5:3] <= 3'h1;
      pt(1, MODE_PULSE_TEST, 3'h2, 5'h0, 5'h0);
      ms(20);
      rc(8'h04, 32'h2, 32'h2);
      pt(1, MODE_PULSE_TEST, 3'h1, 5'h0, 5'h0);
      ms(20);
      rc(8'h04, 32'h2, 32'h2);
      ms(35);
      rc(8'h04, 32'h2, 32'h0);
      // pairs, errors unlatched from here on
      xfer(1'b1, 8'h08, 32'h0);
      for (int i = 2; i < 8; i++)
         pt(i, MODE_SAFETY, 3'h0, 5'h0, 5'h0);
      pr(1, OP_EQUIVALENT, 16'h2);
      pr(2, OP_COMPLEMENTARY, 16'h2);
      pr(3, OP_EQUIVALENT, 16'h0);
      sw[2] <= 1'b1;
      ms(1);
      rc(8'h04, 32'h200, 32'h0);
      ms(3);
      rc(8'h04, 32'h200, 32'h200);
      sw[3] <= 1'b1;
      ms(1);
      rc(8'h04, 32'h200, 32'h0);
      ec(8'h0c, 8'h0c);
      sw[5:4] <= 2'h3;
      ms(4);
      rc(8'h04, 32'h400, 32'h400);
      sw[5] <= 1'b0;
      ms(1);
      rc(8'h04, 32'h400, 32'h0);
      ec(8'h30, 8'h30);
      sw[6] <= 1'b1;
      ms(20);
      rc(8'h04, 32'h800, 32'h0);
      sw[7] <= 1'b1;
      ms(1);
      ec(8'hc0, 8'hc0);
      sw[6] <= 1'b0;
      ms(1);
      sw[6] <= 1'b1;
      ms(1);
      rc(8'h00, 32'h8c0, 32'h800);
      rc(8'h04, 32'h800, 32'h0);
      sw[7:6] <= 2'h0;
      ms(1);
      sw[7:6] <= 2'h3;
      ms(1);
      rc(8'h00, 32'h8c0, 32'hc0);
      // pulse test with no source selected always fails
      pt(1, MODE_PULSE_TEST, 3'h0, 5'h0, 5'h0);
      rc(8'h04, 32'h2, 32'h2);
      // a standard point keeps its pair single
      pt(0, MODE_STANDARD, 3'h0, 5'h0, 5'h0);
      pt(1, MODE_SAFETY, 3'h0, 5'h0, 5'h0);
      feed[5:3] <= 3'h0;
      sw[1:0] <= 2'h1;
      pr(0, OP_EQUIVALENT, 16'h1);
      ms(5);
      rc(8'h04, 32'h100, 32'h0);
      ec(8'h01, 8'h01);
      // delay steps above the top of the range clamp to 21
      pt(2, MODE_SAFETY, 3'h0, 5'h1f, 5'h0);
      rc(8'h28, 32'h3e0, 32'h2a0);
      test_done;
   end
endmodule
